// file: eac_config_regs.sv
// Behaviour
// [R1] Echo count 1..7 stops, zero gives 32
// [R2] Echo count top bits reset to one
// [R3] Software writes zeros to reserved bits
// [R4] Bit 7 picks external common mode
// [R5] Bit 6 picks temperature measurement
// [R6] Bit 5 enables burst damping
// [R7] Measure select at 0x2, resets zero
// [R8] Temp channel bit drops second sensor
// [R9] Sensor class bit selects 500-ohm type
// [R10] Temp clock divide by 8 or burst
// [R11] Blanking enable uses ten-bit timing field
// [R12] Threshold code maps 35 to 1500 mV
// [R13] Temp/echo register at 0x3, resets 0x03
// [R14] Receive mode bit selects multi echo
// [R15] Trigger polarity bit picks falling edge
// [R16] Phase flip position 0..31, resets 31
// [R17] Software avoids phase flip 0 or 1
// [R18] Transmit/receive at 0x4, resets 0x1f
// [R19] Gain/timing-high at 0x5, resets zero
// [R20] Timing joins high bits and low byte
// [R21] Gain code steps 3 dB to 21
// [R22] Missing stops time out with error
// [R23] Fields read back last written value
// [R24] Settings outputs frozen while measurement runs
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_config_regs
   import eac_pkg::*;
#(
   parameter int LISTEN_CYCLES = `EAC_LISTEN_CYCLES
)(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o,
   input wire logic [2:0] burst_div_code_i,
   input wire logic meas_start_i,
   input wire logic stop_pulse_i,
   input wire logic err_clear_i,
   output eac_cfg_t cfg_o,
   output logic meas_busy_o,
   output logic meas_timeout_o,
   output logic meas_error_o
);
   eac_top_state_t st; // Registered bank state
   eac_top_state_t next_st; // Next bank state
   eac_spi_req_t spi_req; // Request from the serial port
   logic [7:0] rd_data; // Read data to the serial port
   logic meas_busy; // Listening window open

   // Expected stop events for a count code
   function automatic logic [5:0] stop_count_of(input logic [2:0] code);
      logic [5:0] n;
      n = {3'h0, code};
      if (code == 3'h0) begin
         n = `EAC_STOP_ALL; // R1
      end
      return n;
   endfunction

   // Threshold magnitude below common mode in mV
   function automatic logic [10:0] threshold_mv_of(input logic [2:0] code);
      logic [10:0] mv;
      mv = 11'h000;
      case (code) // R12
         3'h0: mv = 11'h023;
         3'h1: mv = 11'h032;
         3'h2: mv = 11'h04b;
         3'h3: mv = 11'h07d;
         3'h4: mv = 11'h0dc;
         3'h5: mv = 11'h19a;
         3'h6: mv = 11'h307;
         default: mv = 11'h5dc;
      endcase
      return mv;
   endfunction

   // Amplifier gain in dB for a gain code
   function automatic logic [4:0] gain_db_of(input logic [2:0] code);
      logic [4:0] db;
      db = 5'({2'h0, code} * 5'h03); // R21
      return db;
   endfunction

   // Decode stored bytes into front end settings
   function automatic eac_cfg_t build_cfg(input eac_regs_t r, input logic [2:0] div);
      eac_cfg_t c;
      c = '0;
      c.stop_count = stop_count_of(r.echo_count[2:0]); // R1
      c.common_mode_source = r.measure_select[`EAC_BIT_CM_SRC]; // R4
      c.measure_type = r.measure_select[`EAC_BIT_MEAS_TYPE]; // R5
      c.damping_en = r.measure_select[`EAC_BIT_DAMP]; // R6
      c.temp_ref_one_only = r.temp_echo[`EAC_BIT_TEMP_CH]; // R8
      c.sensor_class_sel = r.temp_echo[`EAC_BIT_SENSOR]; // R9
      // Divider as a power of two: fixed 8, or the burst setting
      if (r.temp_echo[`EAC_BIT_TDIV]) begin
         c.temp_div_log2 = {1'b0, div} + 4'h1; // R10
      end else begin
         c.temp_div_log2 = `EAC_TDIV_FIXED_LOG2; // R10
      end
      // Blanking only applies to standard time-of-flight runs
      c.blanking_en = r.temp_echo[`EAC_BIT_BLANK]
         & ~r.measure_select[`EAC_BIT_MEAS_TYPE]; // R11
      c.echo_threshold_code = r.temp_echo[2:0]; // R12
      c.threshold_mv = threshold_mv_of(r.temp_echo[2:0]); // R12
      c.multi_echo = r.tx_receive[`EAC_BIT_RX_MODE]; // R14
      c.trigger_polarity = r.tx_receive[`EAC_BIT_TRIG]; // R15
      c.phase_flip_position = r.tx_receive[4:0]; // R16
      c.gain_db = gain_db_of(r.gain_high[7:5]); // R21
      c.gain_stage_off = r.gain_high[`EAC_BIT_GAIN_OFF]; // R19
      c.preamp_off = r.gain_high[`EAC_BIT_PREAMP_OFF]; // R19
      c.preamp_feedback = r.gain_high[`EAC_BIT_PREAMP_FB]; // R19
      c.timing = {r.gain_high[1:0], r.timing_low}; // R20
      return c;
   endfunction

   // Read multiplexer; unmapped offsets read zero
   function automatic logic [7:0] reg_read(input eac_regs_t r, input logic [5:0] a);
      logic [7:0] d;
      d = 8'h00;
      case (a) // R23
         `EAC_OFS_ECHO_COUNT: d = r.echo_count;
         `EAC_OFS_MEAS_SEL: d = r.measure_select;
         `EAC_OFS_TEMP_ECHO: d = r.temp_echo;
         `EAC_OFS_TX_RX: d = r.tx_receive;
         `EAC_OFS_GAIN_HIGH: d = r.gain_high;
         `EAC_OFS_TIMING_LOW: d = r.timing_low;
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // Serial port front end
   eac_spi_port u_spi (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_sdi_i(spi_sdi_i),
      .rd_data_i(rd_data),
      .req_o(spi_req),
      .spi_sdo_o(spi_sdo_o),
      .spi_sdo_oe_o(spi_sdo_oe_o)
   );

   // Listening window and stop counting
   eac_echo_watch #(
      .LISTEN_CYCLES(LISTEN_CYCLES)
   ) u_watch (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .start_i(meas_start_i),
      .stop_i(stop_pulse_i),
      .want_i(st.cfg.stop_count), // R22
      .clear_i(err_clear_i),
      .busy_o(meas_busy),
      .timeout_o(meas_timeout_o),
      .error_o(meas_error_o)
   );

   // Read data for the pending read request
   assign rd_data = reg_read(st.regs, spi_req.addr); // R23

   // Register writes and settings update
   always_comb begin
      next_st = st;
      // Whole bytes are stored; reserved bits keep what was written
      if (spi_req.wr) begin
         case (spi_req.addr) // R23
            `EAC_OFS_ECHO_COUNT: next_st.regs.echo_count = spi_req.data; // R2
            `EAC_OFS_MEAS_SEL: next_st.regs.measure_select = spi_req.data; // R7
            `EAC_OFS_TEMP_ECHO: next_st.regs.temp_echo = spi_req.data; // R13
            `EAC_OFS_TX_RX: next_st.regs.tx_receive = spi_req.data; // R18
            `EAC_OFS_GAIN_HIGH: next_st.regs.gain_high = spi_req.data; // R19
            `EAC_OFS_TIMING_LOW: next_st.regs.timing_low = spi_req.data; // R20
            default: next_st.regs = st.regs;
         endcase
      end
      // Settings follow the bytes only while no measurement runs
      if (!meas_busy) begin
         next_st.cfg = build_cfg(st.regs, burst_div_code_i); // R24
      end
   end

   // State register with documented reset bytes
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st.regs <= '{echo_count: `EAC_RST_ECHO_COUNT, // R2
                      measure_select: `EAC_RST_MEAS_SEL, // R7
                      temp_echo: `EAC_RST_TEMP_ECHO, // R13
                      tx_receive: `EAC_RST_TX_RX, // R16 R18
                      gain_high: `EAC_RST_GAIN_HIGH, // R19
                      timing_low: `EAC_RST_TIMING_LOW};
         st.cfg <= '{stop_count: `EAC_STOP_ALL,
                     temp_div_log2: `EAC_TDIV_FIXED_LOG2,
                     echo_threshold_code: 3'h3,
                     threshold_mv: 11'h07d,
                     phase_flip_position: 5'h1f,
                     default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign cfg_o = st.cfg;
   assign meas_busy_o = meas_busy;

   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Reset bytes seen at release
   chk_reset_bytes: assert property ( // R2 R7 R13 R18 R19
      $fell(rst_i) |-> (st.regs.echo_count[7:6] == 2'h1 && st.regs.measure_select == 8'h00
         && st.regs.temp_echo == 8'h03 && st.regs.tx_receive == 8'h1f
         && st.regs.gain_high == 8'h00))
      else $error("bad reset byte");

   // A write lands in its byte
   chk_write_lands: assert property ( // R23
      (spi_req.wr && spi_req.addr == `EAC_OFS_TX_RX)
         |=> st.regs.tx_receive == $past(spi_req.data))
      else $error("write did not land");

   // Read data track the addressed byte
   chk_read_back: assert property ( // R23
      (spi_req.rd && spi_req.addr == `EAC_OFS_TEMP_ECHO) |-> rd_data == st.regs.temp_echo)
      else $error("read data mismatch");

   // Settings frozen while listening
   chk_hold_busy: assert property ( // R24
      meas_busy ##1 meas_busy |-> $stable(st.cfg))
      else $error("settings moved during measurement");

   // Zero count code asks for all stops
   chk_stop_zero: assert property ( // R1
      (!meas_busy && st.regs.echo_count[2:0] == 3'h0) |=> cfg_o.stop_count == 6'h20)
      else $error("count code zero not 32");

   // Highest threshold code
   chk_thr_top: assert property ( // R12
      (!meas_busy && st.regs.temp_echo[2:0] == 3'h7) |=> cfg_o.threshold_mv == 11'h5dc)
      else $error("threshold code 7 wrong");

   // Highest gain code
   chk_gain_top: assert property ( // R21
      (!meas_busy && st.regs.gain_high[7:5] == 3'h7) |=> cfg_o.gain_db == 5'h15)
      else $error("gain code 7 wrong");

   // Timing field joins two bytes
   chk_timing_join: assert property ( // R20
      !meas_busy |=> cfg_o.timing == {$past(st.regs.gain_high[1:0]), $past(st.regs.timing_low)})
      else $error("timing field not joined");

   // Blanking never in temperature mode
   chk_blank_tof: assert property ( // R11
      cfg_o.blanking_en |-> !cfg_o.measure_type)
      else $error("blanking in temperature mode");

   // Fixed temperature divider
   chk_tdiv_fixed: assert property ( // R10
      (!meas_busy && !st.regs.temp_echo[4]) |=> cfg_o.temp_div_log2 == 4'h3)
      else $error("temperature divider not 8");

   // Plain select bits pass through
   chk_select_bits: assert property ( // R4 R6 R15
      !meas_busy |=> (cfg_o.common_mode_source == $past(st.regs.measure_select[7])
         && cfg_o.damping_en == $past(st.regs.measure_select[5])
         && cfg_o.trigger_polarity == $past(st.regs.tx_receive[5])))
      else $error("select bit not passed");

   // Nonzero count code passes straight through
   chk_stop_code: assert property ( // R1
      (!meas_busy && st.regs.echo_count[2:0] != 3'h0)
         |=> cfg_o.stop_count == {3'h0, $past(st.regs.echo_count[2:0])})
      else $error("count code not passed");

   // Default threshold code
   chk_thr_default: assert property ( // R12
      (!meas_busy && st.regs.temp_echo[2:0] == 3'h3) |=> cfg_o.threshold_mv == 11'h07d)
      else $error("threshold code 3 wrong");

   // Amplifier control bits pass through
   chk_amp_bits: assert property ( // R19
      !meas_busy |=> (cfg_o.gain_stage_off == $past(st.regs.gain_high[4])
         && cfg_o.preamp_off == $past(st.regs.gain_high[3])
         && cfg_o.preamp_feedback == $past(st.regs.gain_high[2])))
      else $error("amplifier bit not passed");

   // Mode and channel bits pass through
   chk_mode_bits: assert property ( // R5 R8 R9 R14
      !meas_busy |=> (cfg_o.measure_type == $past(st.regs.measure_select[6])
         && cfg_o.temp_ref_one_only == $past(st.regs.temp_echo[6])
         && cfg_o.sensor_class_sel == $past(st.regs.temp_echo[5])
         && cfg_o.multi_echo == $past(st.regs.tx_receive[6])))
      else $error("mode bit not passed");

   // Phase flip position passes through
   chk_flip_pass: assert property ( // R16
      !meas_busy |=> cfg_o.phase_flip_position == $past(st.regs.tx_receive[4:0]))
      else $error("flip position not passed");
endmodule

// file: eac_consts.svh
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH
// Register offsets on the serial port
`define EAC_OFS_ECHO_COUNT 6'h01
`define EAC_OFS_MEAS_SEL 6'h02
`define EAC_OFS_TEMP_ECHO 6'h03
`define EAC_OFS_TX_RX 6'h04
`define EAC_OFS_GAIN_HIGH 6'h05
`define EAC_OFS_TIMING_LOW 6'h06
// Reset values
`define EAC_RST_ECHO_COUNT 8'h40
`define EAC_RST_MEAS_SEL 8'h00
`define EAC_RST_TEMP_ECHO 8'h03
`define EAC_RST_TX_RX 8'h1f
`define EAC_RST_GAIN_HIGH 8'h00
`define EAC_RST_TIMING_LOW 8'h00
// Field positions
`define EAC_BIT_CM_SRC 7
`define EAC_BIT_MEAS_TYPE 6
`define EAC_BIT_DAMP 5
`define EAC_BIT_TEMP_CH 6
`define EAC_BIT_SENSOR 5
`define EAC_BIT_TDIV 4
`define EAC_BIT_BLANK 3
`define EAC_BIT_RX_MODE 6
`define EAC_BIT_TRIG 5
`define EAC_BIT_GAIN_OFF 4
`define EAC_BIT_PREAMP_OFF 3
`define EAC_BIT_PREAMP_FB 2
`define EAC_BIT_SPI_WRITE 6
// Fixed decode values
`define EAC_STOP_ALL 6'h20
`define EAC_TDIV_FIXED_LOG2 4'h3
// Listening window
`define EAC_CLK_NS 4
`define EAC_LISTEN_NS 8192
`define EAC_LISTEN_CYCLES (`EAC_LISTEN_NS / `EAC_CLK_NS)
`endif

// file: eac_pkg.sv
package eac_pkg;
   // Stored register bytes
   typedef struct packed {
      logic [7:0] echo_count;
      logic [7:0] measure_select;
      logic [7:0] temp_echo;
      logic [7:0] tx_receive;
      logic [7:0] gain_high;
      logic [7:0] timing_low;
   } eac_regs_t;
   // Decoded settings driven to the front end
   typedef struct packed {
      logic [5:0] stop_count;
      logic common_mode_source;
      logic measure_type;
      logic damping_en;
      logic temp_ref_one_only;
      logic sensor_class_sel;
      logic [3:0] temp_div_log2;
      logic blanking_en;
      logic [2:0] echo_threshold_code;
      logic [10:0] threshold_mv;
      logic multi_echo;
      logic trigger_polarity;
      logic [4:0] phase_flip_position;
      logic [4:0] gain_db;
      logic gain_stage_off;
      logic preamp_off;
      logic preamp_feedback;
      logic [9:0] timing;
   } eac_cfg_t;
   // One serial request towards the bank
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] data;
   } eac_spi_req_t;
   // Serial frame phase
   typedef enum logic [1:0] {
      EAC_PH_CMD = 2'b00,
      EAC_PH_DATA = 2'b01,
      EAC_PH_DONE = 2'b10
   } eac_spi_phase_t;
   // Echo watch phase
   typedef enum logic {
      EAC_W_READY = 1'b0,
      EAC_W_LISTEN = 1'b1
   } eac_watch_phase_t;
   // Serial port state
   typedef struct packed {
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic [2:0] sy3;
      logic [2:0] flt;
      eac_spi_phase_t phase;
      logic [2:0] bitcnt;
      logic [7:0] shin;
      logic [5:0] addr;
      logic write;
      logic [7:0] shout;
      logic sdo;
      logic oe;
      eac_spi_req_t req;
   } eac_spi_state_t;
   // Echo watch state
   typedef struct packed {
      eac_watch_phase_t phase;
      logic [5:0] seen;
      logic [15:0] timer;
      logic timeout;
      logic error;
   } eac_watch_state_t;
   // Bank state
   typedef struct packed {
      eac_regs_t regs;
      eac_cfg_t cfg;
   } eac_top_state_t;
endpackage

// file: eac_spi_port.sv
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_spi_port
   import eac_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdi_i,
   input wire logic [7:0] rd_data_i,
   output eac_spi_req_t req_o,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_o
);
   localparam int PS = 0; // Serial clock lane
   localparam int PC = 1; // Select lane
   localparam int PD = 2; // Data-in lane
   eac_spi_state_t st; // Registered state
   eac_spi_state_t next_st; // Next state
   logic [2:0] agree; // Stages two and three agree
   logic [2:0] level; // Filtered pin levels
   logic rise; // Serial clock rose
   logic fall; // Serial clock fell
   logic [7:0] shifted; // Input shifter after this bit

   // Pin filter, frame decode and read-out shifter
   always_comb begin
      next_st = st;
      agree = st.sy2 ~^ st.sy3;
      level = (agree & st.sy3) | (~agree & st.flt);
      rise = level[PS] & ~st.flt[PS];
      fall = ~level[PS] & st.flt[PS];
      shifted = {st.shin[6:0], level[PD]};
      next_st.sy1 = {spi_sdi_i, spi_cs_n_i, spi_sclk_i};
      next_st.sy2 = st.sy1;
      next_st.sy3 = st.sy2;
      next_st.flt = level;
      next_st.req = '0;
      // Read data arrive one cycle after the request
      if (st.req.rd) begin
         next_st.shout = rd_data_i;
      end
      if (level[PC]) begin
         // Deselect ends any frame and rearms
         next_st.phase = EAC_PH_CMD;
         next_st.bitcnt = 3'h0;
         next_st.oe = 1'b0;
      end else if (rise) begin
         next_st.shin = shifted;
         next_st.bitcnt = st.bitcnt + 3'h1;
         if (st.bitcnt == 3'h7) begin
            case (st.phase)
               EAC_PH_CMD: begin
                  next_st.addr = shifted[5:0];
                  next_st.write = shifted[`EAC_BIT_SPI_WRITE];
                  next_st.phase = EAC_PH_DATA;
                  next_st.req.rd = ~shifted[`EAC_BIT_SPI_WRITE];
                  next_st.req.addr = shifted[5:0];
               end
               EAC_PH_DATA: begin
                  next_st.phase = EAC_PH_DONE;
                  next_st.oe = 1'b0;
                  next_st.req.wr = st.write;
                  next_st.req.addr = st.addr;
                  next_st.req.data = shifted;
               end
               default: begin
                  next_st.phase = EAC_PH_DONE;
               end
            endcase
         end
      end else if (fall && st.phase == EAC_PH_DATA && !st.write) begin
         // Shift read data out, MSB first
         next_st.sdo = st.shout[7];
         next_st.shout = {st.shout[6:0], 1'b0};
         next_st.oe = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{sy1: 3'h2, sy2: 3'h2, sy3: 3'h2, flt: 3'h2, phase: EAC_PH_CMD, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign req_o = st.req;
   assign spi_sdo_o = st.sdo;
   assign spi_sdo_oe_o = st.oe;
endmodule

// file: eac_echo_watch.sv
`timescale 1ns/1ps
`include "eac_consts.svh"
module eac_echo_watch
   import eac_pkg::*;
#(
   parameter int LISTEN_CYCLES = `EAC_LISTEN_CYCLES
)(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic [5:0] want_i,
   input wire logic clear_i,
   output logic busy_o,
   output logic timeout_o,
   output logic error_o
);
   localparam logic [15:0] LAST = 16'(LISTEN_CYCLES - 1); // Window end
   eac_watch_state_t st; // Registered state
   eac_watch_state_t next_st; // Next state

   // Count stop events inside the listening window
   always_comb begin
      next_st = st;
      next_st.timeout = 1'b0;
      if (clear_i) begin
         next_st.error = 1'b0;
      end
      case (st.phase)
         EAC_W_READY: begin
            if (start_i) begin
               next_st.phase = EAC_W_LISTEN;
               next_st.seen = 6'h00;
               next_st.timer = LAST;
            end
         end
         EAC_W_LISTEN: begin
            if (stop_i && (6'(st.seen + 6'h01) == want_i)) begin
               next_st.phase = EAC_W_READY;
            end else if (st.timer == 16'h0000) begin
               // Short of stops: back to ready, flag wins over clear
               next_st.phase = EAC_W_READY; // R22
               next_st.timeout = 1'b1; // R22
               next_st.error = 1'b1; // R22
            end else begin
               next_st.seen = stop_i ? 6'(st.seen + 6'h01) : st.seen;
               next_st.timer = st.timer - 16'h0001;
            end
         end
         default: begin
            next_st.phase = EAC_W_READY;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '{phase: EAC_W_READY, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign busy_o = (st.phase == EAC_W_LISTEN);
   assign timeout_o = st.timeout;
   assign error_o = st.error;

   chk_timeout_err: assert property (@(posedge clock_i) disable iff (rst_i) // R22
      (busy_o && st.timer == 16'h0000 && !stop_i) |=> (timeout_o && error_o && !busy_o))
      else $error("window end did not time out");
endmodule

// file: eac_host_model.sv
`timescale 1ns/1ps
module eac_host_model (
   input wire logic clock_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o
);
   // Clocks per serial clock phase, twice the minimum
   localparam int HALF = 8;
   // Idle bus: deselected, serial clock parked low
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b1;
   end
   // Wait a number of falling clock edges
   task automatic idle(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // One frame: command byte then data byte, MSB first
   task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {1'b0, wr, addr, wdata};
      rdata = 8'h00;
      idle(1);
      cs_n_o = 1'b0;
      idle(HALF);
      for (int i = 15; i >= 0; i--) begin
         sdi_o = frame[i];
         idle(HALF);
         sclk_o = 1'b1;
         // Undriven output line counts as unknown
         if (i < 8) begin
            rdata[i] = sdo_oe_i ? sdo_i : 1'bx;
         end
         idle(HALF);
         sclk_o = 1'b0;
      end
      idle(HALF);
      cs_n_o = 1'b1;
      // Released data line shows the inverse of its last value
      sdi_o = ~sdi_o;
      idle(HALF);
   endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
   import eac_pkg::*;
   localparam int LC = 400; // Short listening window
   logic clock_i, rst_i, sclk, cs_n, sdi, sdo, sdo_oe, start, stop, clr, busy, tmo, err;
   logic [2:0] bdiv; // Burst divider code
   logic [7:0] rd; // Read data
   eac_cfg_t cfg; // Decoded settings
   int fail_count, checks_done, cycles, tmo_seen;
   eac_config_regs #(.LISTEN_CYCLES(LC)) DUT (.clock_i(clock_i), .rst_i(rst_i),
      .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
      .spi_sdo_oe_o(sdo_oe), .burst_div_code_i(bdiv), .meas_start_i(start),
      .stop_pulse_i(stop), .err_clear_i(clr), .cfg_o(cfg), .meas_busy_o(busy),
      .meas_timeout_o(tmo), .meas_error_o(err));
   eac_host_model HOST (.clock_i(clock_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
      .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
   // Clock generator
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard and timeout pulse counter
   always @(posedge clock_i) begin
      cycles++;
      if (tmo === 1'b1) begin
         tmo_seen++;
      end
      if (cycles == 60000) begin
         fail_count++;
         $display("unexpected at %0t: run hung", $time);
         print_verdict();
      end
   end
   // Compare one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Register write
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      HOST.xfer(1'b1, a, d, rd);
   endtask
   // Register read and compare
   task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
      HOST.xfer(1'b0, a, 8'h00, rd);
      chk(16'(rd), 16'(exp), "read data");
   endtask
   // Wait for the listening window to close, bounded
   task automatic wait_idle(input int lim);
      int n;
      n = 0;
      while (busy === 1'b1 && n < lim) begin
         @(negedge clock_i);
         n++;
      end
      chk(16'(busy), 16'h0, "busy after window");
   endtask
   // Reset bytes and reset decode
   task automatic t_reset();
      chk(16'(cfg.stop_count), 16'h20, "reset stops");
      chk(16'(cfg.threshold_mv), 16'h7d, "reset threshold");
      chk(16'(cfg.phase_flip_position), 16'h1f, "reset flip");
      chk(16'(cfg.temp_div_log2), 16'h3, "reset divide");
      chk(16'({cfg.common_mode_source, cfg.measure_type, cfg.damping_en}), 16'h0, "bits");
      chk(16'({cfg.temp_ref_one_only, cfg.sensor_class_sel, cfg.blanking_en}), 16'h0, "t");
      chk(16'({cfg.multi_echo, cfg.trigger_polarity}), 16'h0, "rx bits");
      rdchk(6'h01, 8'h40);
      rdchk(6'h02, 8'h00);
      rdchk(6'h03, 8'h03);
      rdchk(6'h04, 8'h1f);
      rdchk(6'h05, 8'h00);
      rdchk(6'h06, 8'h00);
      $display("test reset done");
   endtask
   // Sweep of every three-bit code
   task automatic t_sweep();
      logic [10:0] mv [8];
      mv = '{11'd35, 11'd50, 11'd75, 11'd125, 11'd220, 11'd410, 11'd775, 11'd1500};
      for (int c = 0; c < 8; c++) begin
         wr(6'h01, {5'b01000, 3'(c)});
         wr(6'h03, {5'h00, 3'(c)});
         wr(6'h05, {3'(c), 5'h00});
         chk(16'(cfg.stop_count), (c == 0) ? 16'h20 : 16'(c), "stops");
         chk(16'(cfg.threshold_mv), 16'(mv[c]), "threshold");
         chk(16'(cfg.echo_threshold_code), 16'(c), "code");
         chk(16'(cfg.gain_db), 16'(3 * c), "gain");
         rdchk(6'h03, {5'h00, 3'(c)});
      end
      $display("test sweep done");
   endtask
   // Single-bit fields, timing join, unmapped places
   task automatic t_fields();
      wr(6'h02, 8'he0);
      chk(16'({cfg.common_mode_source, cfg.measure_type, cfg.damping_en}), 16'h7, "b");
      wr(6'h03, 8'h7b);
      chk(16'(cfg.temp_ref_one_only), 16'h1, "channels");
      chk(16'(cfg.sensor_class_sel), 16'h1, "sensor");
      chk(16'(cfg.temp_div_log2), 16'h6, "divide");
      chk(16'(cfg.blanking_en), 16'h0, "blank in temp");
      wr(6'h02, 8'h00);
      chk(16'(cfg.blanking_en), 16'h1, "blank");
      wr(6'h04, 8'h62);
      chk(16'({cfg.multi_echo, cfg.trigger_polarity}), 16'h3, "rx bits");
      chk(16'(cfg.phase_flip_position), 16'h2, "flip");
      wr(6'h05, 8'h1f);
      wr(6'h06, 8'h5a);
      chk(16'({cfg.gain_stage_off, cfg.preamp_off, cfg.preamp_feedback}), 16'h7, "amp");
      chk(16'(cfg.timing), 16'h35a, "timing");
      rdchk(6'h04, 8'h62);
      wr(6'h00, 8'hff);
      rdchk(6'h00, 8'h00);
      rdchk(6'h07, 8'h00);
      $display("test fields done");
   endtask
   // Completed window, then timeout with a write held back
   task automatic t_measure();
      wr(6'h01, 8'h42);
      start = 1'b1;
      @(negedge clock_i);
      start = 1'b0;
      chk(16'(busy), 16'h1, "busy");
      repeat (2) begin
         stop = 1'b1;
         @(negedge clock_i);
         stop = 1'b0;
         @(negedge clock_i);
      end
      wait_idle(8);
      chk(16'({tmo_seen[3:0], err}), 16'h0, "no timeout");
      start = 1'b1;
      @(negedge clock_i);
      start = 1'b0;
      wr(6'h04, 8'h65);
      chk(16'(cfg.phase_flip_position), 16'h2, "frozen");
      wait_idle(LC + 20);
      chk(16'(cfg.phase_flip_position), 16'h2, "held at close");
      @(negedge clock_i);
      chk(16'({tmo_seen[3:0], err}), 16'h3, "timeout");
      @(negedge clock_i);
      chk(16'(cfg.phase_flip_position), 16'h5, "released");
      clr = 1'b1;
      @(negedge clock_i);
      clr = 1'b0;
      @(negedge clock_i);
      chk(16'(err), 16'h0, "error cleared");
      $display("test measure done");
   endtask
   // Main sequence
   initial begin
      rst_i = 1'b1;
      start = 1'b0;
      stop = 1'b0;
      clr = 1'b0;
      bdiv = 3'h5;
      repeat (6) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (8) @(negedge clock_i);
      t_reset();
      t_sweep();
      t_fields();
      t_measure();
      print_verdict();
   end
endmodule
